// ===== design/gdc_ctrl.sv
`timescale 1ns/1ps
module gdc_ctrl
    import gdc_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int CNT_W = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic error_line_n,
    output logic gate_cmd_noninv,
    output logic gate_cmd_inv,
    output logic drv_reset_n
);
    // refuse shapes the decode and counters cannot serve, at elaboration
    if (ADDR_W < 4 || ADDR_W > 8) begin : g_bad_addr_w
        $error("gdc_ctrl: ADDR_W must be 4..8");
    end
    if (CNT_W < 8 || CNT_W > 16) begin : g_bad_cnt_w
        $error("gdc_ctrl: CNT_W must be 8..16");
    end

    localparam logic [CNT_W-1:0] SETTLE_CNT = CNT_W'(GDC_SETTLE_CYC);

    logic error_line_s; // synchronised error line, high when released
    logic fault_low; // error line pulled low by some driver
    logic gate_on_r; // software gate request
    logic inv_mode_r; // 1: inverting input wiring
    logic fault_seen_r; // sticky record of a low error line
    logic fault_hold_r; // gate held off until a reset sequence ends
    logic [CNT_W-1:0] rlen_r; // reset pulse length in cycles
    logic [CNT_W-1:0] cnt_r; // sequencer counter
    gdc_state_t state_r; // reset sequencer state
    gdc_state_t state_nxt;
    logic run_gate; // gate wanted on this cycle
    logic noninv_nxt;
    logic inv_nxt;
    logic wr_acc; // write taken this cycle
    logic clr_req; // write-one to the clear bit
    logic [31:0] rd_nxt;
    logic err_nxt;
    logic pready_r;
    logic [31:0] prdata_r;
    logic pslverr_r;
    logic noninv_r;
    logic inv_r;
    logic reset_n_r;

    // decoded address hit, shared by read and write paths
    function automatic logic [1:0] dec_addr(input logic [ADDR_W-1:0] a);
        logic [7:0] a8;
        a8 = 8'(a);
        if (a8 == GDC_CTRL_OFS) begin
            dec_addr = 2'h1;
        end else if (a8 == GDC_STAT_OFS) begin
            dec_addr = 2'h2;
        end else if (a8 == GDC_RLEN_OFS) begin
            dec_addr = 2'h3;
        end else begin
            dec_addr = 2'h0;
        end
    endfunction : dec_addr

    // the error line is an open-collector net from outside, so it is synchronised
    gdc_sync2 #(
        .RST_VAL(1'b1)
    ) u_err_sync (
        .clk(pclk),
        .rst_n(presetn),
        .din(error_line_n),
        .dout(error_line_s)
    );

    // low means some driver on the wired line reports an error
    assign fault_low = !error_line_s;

    // apb: answer in the first access cycle, data prepared during setup
    assign wr_acc = psel && penable && pready_r && pwrite;
    assign clr_req = wr_acc && (dec_addr(paddr) == 2'h1) && pwdata[GDC_CTRL_CLR_BIT];

    // read mux and error flag for the setup cycle
    always_comb begin
        rd_nxt = 32'h0000_0000;
        err_nxt = 1'b0;
        if (dec_addr(paddr) == 2'h1) begin
            rd_nxt[GDC_CTRL_GATE_BIT] = gate_on_r;
            rd_nxt[GDC_CTRL_INV_BIT] = inv_mode_r;
        end else if (dec_addr(paddr) == 2'h2) begin
            rd_nxt[GDC_STAT_SEEN_BIT] = fault_seen_r;
            rd_nxt[GDC_STAT_LINE_BIT] = fault_low;
            rd_nxt[GDC_STAT_BUSY_BIT] = (state_r != GDC_RUN);
            rd_nxt[GDC_STAT_GATE_BIT] = run_gate;
        end else if (dec_addr(paddr) == 2'h3) begin
            rd_nxt = 32'(rlen_r);
        end else begin
            // unmapped: error answer, data zero
            err_nxt = 1'b1;
        end
    end

    // apb answer flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= psel && !penable;
            prdata_r <= (psel && !penable && !pwrite) ? rd_nxt : 32'h0000_0000;
            pslverr_r <= psel && !penable && err_nxt;
        end
    end

    // software control and reset length
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_on_r <= GDC_CTRL_RST[GDC_CTRL_GATE_BIT];
            inv_mode_r <= GDC_CTRL_RST[GDC_CTRL_INV_BIT];
            rlen_r <= CNT_W'(GDC_RLEN_RST);
        end else if (wr_acc && dec_addr(paddr) == 2'h1) begin
            gate_on_r <= pwdata[GDC_CTRL_GATE_BIT];
            inv_mode_r <= pwdata[GDC_CTRL_INV_BIT];
        end else if (wr_acc && dec_addr(paddr) == 2'h3) begin
            // zero would never end the pulse, so it reads back as one
            rlen_r <= (pwdata[CNT_W-1:0] == '0) ? CNT_W'(1) : pwdata[CNT_W-1:0];
        end
    end

    // sticky status: write one clears, a low line in the same cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_seen_r <= 1'b0;
        end else if (fault_low) begin
            fault_seen_r <= 1'b1;
        end else if (wr_acc && dec_addr(paddr) == 2'h2 && pwdata[GDC_STAT_SEEN_BIT]) begin
            fault_seen_r <= 1'b0;
        end
    end

    // hold the gate off after an error until the reset sequence completes;
    // the driver already forces its gate off, this keeps our command honest
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_hold_r <= 1'b0;
        end else if (fault_low && state_r == GDC_RUN) begin
            fault_hold_r <= 1'b1;
        end else if (state_r == GDC_RECOVER && cnt_r == CNT_W'(1)) begin
            fault_hold_r <= 1'b0;
        end
    end

    // sequencer next state: settle with inputs off, pulse reset, settle again
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            GDC_RUN: begin
                if (clr_req) begin
                    state_nxt = GDC_SAFE;
                end
            end
            GDC_SAFE: begin
                if (cnt_r == CNT_W'(1)) begin
                    state_nxt = GDC_PULSE;
                end
            end
            GDC_PULSE: begin
                if (cnt_r == CNT_W'(1)) begin
                    state_nxt = GDC_RECOVER;
                end
            end
            GDC_RECOVER: begin
                if (cnt_r == CNT_W'(1)) begin
                    state_nxt = GDC_RUN;
                end
            end
            default: begin
                state_nxt = GDC_RUN;
            end
        endcase
    end

    // sequencer state and its counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= GDC_RUN;
            cnt_r <= '0;
        end else begin
            state_r <= state_nxt;
            if (state_r == GDC_RUN && state_nxt == GDC_SAFE) begin
                cnt_r <= SETTLE_CNT;
            end else if (state_r == GDC_SAFE && state_nxt == GDC_PULSE) begin
                cnt_r <= rlen_r;
            end else if (state_r == GDC_PULSE && state_nxt == GDC_RECOVER) begin
                cnt_r <= SETTLE_CNT;
            end else if (cnt_r != '0) begin
                cnt_r <= cnt_r - CNT_W'(1);
            end
        end
    end

    // the gate is commanded only in run, with no error pending
    assign run_gate = (state_r == GDC_RUN) && !fault_hold_r && !fault_low && gate_on_r;

    // pin encoding; both inputs always actively driven, never left floating
    always_comb begin
        if (inv_mode_r) begin
            noninv_nxt = 1'b1;
            inv_nxt = !run_gate;
        end else begin
            noninv_nxt = run_gate;
            inv_nxt = 1'b0;
        end
    end

    // pin flops; push-pull outputs straight from registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            noninv_r <= 1'b0;
            inv_r <= 1'b0;
            reset_n_r <= 1'b1;
        end else begin
            noninv_r <= noninv_nxt;
            inv_r <= inv_nxt;
            reset_n_r <= (state_nxt != GDC_PULSE);
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign gate_cmd_noninv = noninv_r;
    assign gate_cmd_inv = inv_r;
    assign drv_reset_n = reset_n_r;

    // steps of a clear: inputs go off, then reset falls
    sequence s_inputs_off;
        (!noninv_r || inv_r);
    endsequence

    sequence s_reset_low;
        !reset_n_r;
    endsequence

    chk_reset_inputs_off: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_reset_low |-> s_inputs_off
    ) else $error("driver reset low while gate inputs command on");

    chk_clear_before_pulse: assert property (
        @(posedge pclk) disable iff (!presetn)
        $fell(reset_n_r) |-> $past(!noninv_r || inv_r) ##0 s_inputs_off
    ) else $error("reset pulse began without inputs already off");

    chk_noninv_mode_low: assert property (
        @(posedge pclk) disable iff (!presetn)
        ($past(inv_mode_r) == 1'b0 && $past(presetn)) |-> (inv_r == 1'b0)
    ) else $error("inverting input not held low in non-inverting mode");

    chk_inv_mode_high: assert property (
        @(posedge pclk) disable iff (!presetn)
        ($past(inv_mode_r) && $past(presetn)) |-> (noninv_r == 1'b1)
    ) else $error("non-inverting input not held high in inverting mode");

    chk_gate_follows: assert property (
        @(posedge pclk) disable iff (!presetn)
        run_gate |=> (noninv_r && !inv_r)
    ) else $error("gate command pins do not show on");

    chk_fault_sticky: assert property (
        @(posedge pclk) disable iff (!presetn)
        fault_low |=> fault_seen_r
    ) else $error("low error line not recorded");

    chk_pulse_length: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(state_r == GDC_PULSE) |-> (cnt_r == $past(rlen_r)) ##0 s_reset_low
    ) else $error("reset pulse not loaded with programmed length");

    chk_fault_gate_off: assert property (
        @(posedge pclk) disable iff (!presetn)
        fault_hold_r |=> s_inputs_off
    ) else $error("gate commanded on while an error is held");
endmodule : gdc_ctrl

// ===== design/gdc_pkg.sv
package gdc_pkg;
    // register byte offsets on the apb side
    localparam logic [7:0] GDC_CTRL_OFS = 8'h00;
    localparam logic [7:0] GDC_STAT_OFS = 8'h04;
    localparam logic [7:0] GDC_RLEN_OFS = 8'h08;
    // control register fields
    localparam int GDC_CTRL_GATE_BIT = 0;
    localparam int GDC_CTRL_INV_BIT = 1;
    localparam int GDC_CTRL_CLR_BIT = 2;
    // status register fields
    localparam int GDC_STAT_SEEN_BIT = 0;
    localparam int GDC_STAT_LINE_BIT = 1;
    localparam int GDC_STAT_BUSY_BIT = 2;
    localparam int GDC_STAT_GATE_BIT = 3;
    // reset values
    localparam logic [31:0] GDC_CTRL_RST = 32'h0000_0000;
    localparam logic [15:0] GDC_RLEN_RST = 16'h007D;
    // timing: clock period and settle time around the reset pulse
    localparam int GDC_CLK_PERIOD_PS = 8000;
    localparam int GDC_SETTLE_NS = 1000;
    // least time, so round up
    localparam int GDC_SETTLE_CYC = (GDC_SETTLE_NS * 1000 + GDC_CLK_PERIOD_PS - 1)
                                    / GDC_CLK_PERIOD_PS;
    // sequencer states, one-hot
    typedef enum logic [3:0] {
        GDC_RUN = 4'b0001,
        GDC_SAFE = 4'b0010,
        GDC_PULSE = 4'b0100,
        GDC_RECOVER = 4'b1000
    } gdc_state_t;
endpackage : gdc_pkg

// ===== design/gdc_sync2.sv
`timescale 1ns/1ps
// two-flop synchroniser for an asynchronous pin level
module gdc_sync2 #(
    parameter logic RST_VAL = 1'b1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic din,
    output logic dout
);
    logic meta_r; // first stage, read only by the second stage
    logic sync_r; // second stage

    // both stages reset to the idle level of the line
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= RST_VAL;
            sync_r <= RST_VAL;
        end else begin
            meta_r <= din;
            sync_r <= meta_r;
        end
    end

    assign dout = sync_r;
endmodule : gdc_sync2

// ===== test/gdc_drv_model.sv
`timescale 1ns/1ps
// behavioural isolated gate driver, seen from its control pins
module gdc_drv_model #(
    parameter int BLANK_NS = 2800 // sense ignored this long after turn-on
) (
    input wire logic gate_cmd_noninv,
    input wire logic gate_cmd_inv,
    input wire logic drv_reset_n,
    input wire logic sat_sense_hi, // sense node above trip level
    input wire logic supply_ok, // output side above lockout
    output logic err_oe_n, // low while this driver pulls the error line low
    output logic gate_out // transistor gate high
);
    logic latched_r = 1'b0; // input side error latch
    logic out_err_r = 1'b0; // output side error state
    logic iso_on; // isolated gate signal
    logic iso_dly; // gate signal seen after blanking
    // gate signal needs noninv high, inv low and no latched error
    assign iso_on = gate_cmd_noninv & ~gate_cmd_inv & ~latched_r;
    // inertial delay: an on pulse shorter than blanking never arms sensing
    assign #(BLANK_NS) iso_dly = iso_on;
    // sensing works whatever the supply, so it is armed before lockout ends
    always @* begin
        if (!iso_on) begin
            out_err_r = 1'b0;
        end else if (iso_dly && sat_sense_hi) begin
            out_err_r = 1'b1;
        end
    end
    // latch sets on an output fault and clears only while reset is low
    always @(posedge out_err_r or negedge drv_reset_n) begin
        if (!drv_reset_n) begin
            latched_r <= 1'b0;
        end else begin
            latched_r <= 1'b1;
        end
    end
    assign err_oe_n = ~latched_r;
    // soft discharge and final clamp both end with the gate low
    assign gate_out = supply_ok & iso_on & ~out_err_r;
endmodule : gdc_drv_model

// ===== test/test_gdc_ctrl.sv
`timescale 1ns/1ps
module test_gdc_ctrl
    import gdc_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic pready, pslverr, e, error_line_n, noninv, inv, drv_reset_n;
    logic sat_hi, supply_ok, err_oe_n, other_oe_n, gate_out;
    int num_errors = 0, total_checks = 0, cycles = 0, rst_low_cnt = 0, bad_reset_cnt = 0, t0 = 0;
    // pulled-up line, wire-or of the model and a second driver
    assign error_line_n = (err_oe_n & other_oe_n) ? 1'b1 : 1'b0;
    gdc_ctrl #(.ADDR_W(8), .CNT_W(16)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .error_line_n(error_line_n),
        .gate_cmd_noninv(noninv), .gate_cmd_inv(inv), .drv_reset_n(drv_reset_n));
    gdc_drv_model drv (.gate_cmd_noninv(noninv), .gate_cmd_inv(inv), .drv_reset_n(drv_reset_n),
        .sat_sense_hi(sat_hi), .supply_ok(supply_ok), .err_oe_n(err_oe_n), .gate_out(gate_out));
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : results
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // one apb transfer; held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, exp, q);
    endtask : rd
    // let the sync and pin latency pass, with one edge spare for a line
    // that changes in the same time step as a clock edge
    task automatic pins(input logic [1:0] exp);
        repeat (4) @(posedge pclk);
        chk("pins", {30'h0, exp}, {30'h0, noninv, inv});
    endtask : pins
    // start the clear sequence and poll busy under a bound
    task automatic clear_seq();
        int n;
        rst_low_cnt = 0;
        apb(1'b1, GDC_CTRL_OFS, 32'h4);
        for (n = 0; n < 200; n++) begin
            apb(1'b0, GDC_STAT_OFS, 32'h0);
            if (q[GDC_STAT_BUSY_BIT] === 1'b0) break;
        end
        chk("reset pulse cycles", 32'h2, rst_low_cnt);
        chk("unsafe reset cycles", 32'h0, bad_reset_cnt);
        chk("error line", 32'h1, {31'h0, error_line_n});
    endtask : clear_seq
    // count reset pulse cycles, catch gate-on during reset, cut hangs
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (!drv_reset_n) begin
            rst_low_cnt++;
            if (noninv && !inv) bad_reset_cnt++;
        end
        if (cycles == 5000) begin
            num_errors++;
            results();
        end
    end
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
        pwdata = 32'h0; sat_hi = 1'b0; supply_ok = 1'b1; other_oe_n = 1'b1;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd("ctrl", GDC_CTRL_OFS, GDC_CTRL_RST);
        rd("rlen", GDC_RLEN_OFS, {16'h0000, GDC_RLEN_RST});
        rd("stat", GDC_STAT_OFS, 32'h0);
        pins(2'b00);
        chk("drv reset", 32'h1, {31'h0, drv_reset_n});
        $display("test reset values done");
        apb(1'b1, GDC_RLEN_OFS, 32'h0);
        rd("rlen zero", GDC_RLEN_OFS, 32'h1);
        apb(1'b1, GDC_RLEN_OFS, 32'h2);
        rd("rlen", GDC_RLEN_OFS, 32'h2);
        apb(1'b1, 8'h0C, 32'hFFFF_FFFF);
        chk("wr slverr", 32'h1, {31'h0, e});
        apb(1'b0, 8'h0C, 32'h0);
        chk("rd slverr", 32'h1, {31'h0, e});
        chk("rd unmapped", 32'h0, q);
        $display("test registers done");
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, GDC_CTRL_OFS, k);
            pins(k[1] ? {1'b1, ~k[0]} : {k[0], 1'b0});
            chk("gate", {31'h0, k[0]}, {31'h0, gate_out});
        end
        supply_ok <= 1'b0;
        pins(2'b10);
        chk("gate in lockout", 32'h0, {31'h0, gate_out});
        supply_ok <= 1'b1;
        pins(2'b10);
        chk("gate after lockout", 32'h1, {31'h0, gate_out});
        $display("test modes done");
        apb(1'b1, GDC_CTRL_OFS, 32'h0);
        sat_hi <= 1'b1;
        apb(1'b1, GDC_CTRL_OFS, 32'h1);
        t0 = cycles;
        repeat (100) @(posedge pclk);
        chk("line in blanking", 32'h1, {31'h0, error_line_n});
        for (int n = 0; n < 1000 && error_line_n; n++) @(posedge pclk);
        chk("fault delay", 32'h1, {31'h0, (cycles - t0 >= 340) && (cycles - t0 <= 380)});
        pins(2'b00);
        chk("gate after fault", 32'h0, {31'h0, gate_out});
        apb(1'b0, GDC_STAT_OFS, 32'h0);
        chk("stat fault", 32'h3, q & 32'h3);
        apb(1'b1, GDC_CTRL_OFS, 32'h1);
        pins(2'b00);
        sat_hi <= 1'b0;
        clear_seq();
        apb(1'b1, GDC_STAT_OFS, 32'h1);
        rd("stat cleared", GDC_STAT_OFS, 32'h0);
        apb(1'b1, GDC_CTRL_OFS, 32'h0);
        apb(1'b1, GDC_CTRL_OFS, 32'h1);
        pins(2'b10);
        $display("test fault and clear done");
        other_oe_n <= 1'b0;
        pins(2'b00);
        apb(1'b0, GDC_STAT_OFS, 32'h0);
        chk("stat line", 32'h2, q & 32'h2);
        other_oe_n <= 1'b1;
        clear_seq();
        apb(1'b1, GDC_CTRL_OFS, 32'h0);
        apb(1'b1, GDC_CTRL_OFS, 32'h1);
        pins(2'b10);
        $display("test shared line done");
        results();
    end
endmodule : test_gdc_ctrl
